// ==== bench/bmon_ram_model.sv ====
// Shared RAM and arbiter model on the far side of the monitor's RAM port.
// Assumes one clock; read data is valid only in the cycle after a granted read.
`timescale 1ns/10ps
`default_nettype none
module bmon_ram_model
   import bmon_pkg::*;
(
   input wire logic clk_in,
   input wire logic stall_in,
   input wire bmon_ram_req_type req_in,
   output var logic gnt_out,
   output var logic [15:0] rdata_out
);
   logic [15:0] mem [0:65535];
   initial rdata_out = 16'h0000;
   // A stalled arbiter withholds the grant, so the monitor must hold its request.
   assign gnt_out = !stall_in;
   // Stale read data is inverted every cycle so it never looks like a fresh answer.
   always @(posedge clk_in) begin
      if (req_in.req && gnt_out && req_in.we)
         mem[req_in.addr] <= req_in.wdata;
      rdata_out <= (req_in.req && gnt_out && !req_in.we) ? mem[req_in.addr] : ~rdata_out;
   end
endmodule // bmon_ram_model
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the bus monitor: APB master, receiver words, RAM model.
// Assumes the RAM model above and zero-wait APB answers.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import bmon_pkg::*;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, ext = 0, stall = 0, pready, pslverr, irq, gnt;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [15:0] rdata;
   bmon_rx_word_type rx = '0;
   bmon_ram_req_type ram;
   int fail_count = 0, n_tests = 0, irqs = 0;
   always #2.5 clk = ~clk;
   // Count one-cycle interrupt pulses.
   always @(posedge clk) if (irq === 1'b1) irqs++;
   bmon_top bmon_top_i(.core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .rx_word_in(rx), .external_capture_start_input_in(ext),
      .terminal_address_bits_in(5'h05), .ram_out(ram), .ram_gnt_in(gnt), .ram_rdata_in(rdata),
      .pattern_irq_out(irq));
   bmon_ram_model bmon_ram_model_i(.clk_in(clk), .stall_in(stall), .req_in(ram), .gnt_out(gnt),
      .rdata_out(rdata));
   task automatic summarize();
      $display("mismatches %0d comparisons %0d", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; the request is held until pready is sampled high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) pen <= 1;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
      if (n >= 20) begin
         fail_count++;
         summarize();
      end
      rd = prdata;
      psel <= 0;
      pen <= 0;
      @(posedge clk);
   endtask
   task automatic send(input logic [15:0] d, input logic b, input logic s);
      rx <= '{1'b1, d, b, s, 1'b0};
      @(posedge clk) rx.strobe <= 1'b0;
      repeat (12) @(posedge clk);
   endtask
   // Word mode from a pointer two below 0100, then a wrap in the small RAM with a stalled arbiter.
   task automatic word_mode();
      bmon_ram_model_i.mem[16'h0100] = 16'h00FE;
      apb(1, 12'h000, 32'h0000_0001);
      apb(1, 12'h004, 32'h0000_0001);
      repeat (4) @(posedge clk);
      send(16'hA5A5, 0, 0);
      send(16'h5A5A, 1, 1);
      check(bmon_ram_model_i.mem[16'h00FE], 16'hA5A5);
      check(bmon_ram_model_i.mem[16'h00FF] >> 13, 3'b010);
      check(bmon_ram_model_i.mem[16'h0100], 16'h5A5A);
      check(bmon_ram_model_i.mem[16'h0101] >> 13, 3'b111);
      apb(0, 12'h010, 0);
      check(rd, 32'h0000_0102);
      apb(1, 12'h004, 32'h0000_0002);
      bmon_ram_model_i.mem[16'h0100] = 16'h0FFE;
      stall <= 1;
      apb(1, 12'h000, 32'h0000_0041);
      apb(1, 12'h004, 32'h0000_0001);
      repeat (6) @(posedge clk);
      stall <= 0;
      send(16'h1111, 0, 0);
      send(16'h2222, 0, 0);
      check(bmon_ram_model_i.mem[16'h0000], 16'h2222);
   endtask
   // Pattern interrupt masked then unmasked, then stop on trigger, then an external start.
   task automatic trigger();
      apb(1, 12'h008, 32'h0000_1234);
      send(16'h1234, 0, 0);
      check(irqs, 0);
      apb(1, 12'h00C, 32'h0000_0001);
      send(16'h1234, 0, 0);
      check(irqs, 1);
      apb(1, 12'h004, 32'h0000_0002);
      bmon_ram_model_i.mem[16'h0100] = 16'h0300;
      bmon_ram_model_i.mem[16'h0302] = 16'hDEAD;
      apb(1, 12'h000, 32'h0000_0029);
      apb(1, 12'h004, 32'h0000_0001);
      repeat (4) @(posedge clk);
      send(16'h1234, 0, 0);
      send(16'h7777, 0, 0);
      check(bmon_ram_model_i.mem[16'h0300], 16'h1234);
      check(bmon_ram_model_i.mem[16'h0302], 16'hDEAD);
      bmon_ram_model_i.mem[16'h0100] = 16'h0200;
      apb(1, 12'h000, 32'h0000_0001);
      ext <= 1;
      repeat (8) @(posedge clk);
      send(16'h3333, 1, 0);
      check(bmon_ram_model_i.mem[16'h0200], 16'h3333);
   endtask
   // Selective mode: receive to terminal 3, subaddress 2, one data word, enabled in the table.
   task automatic selective();
      apb(1, 12'h004, 32'h0000_0002);
      bmon_ram_model_i.mem[16'h0102] = 16'h0400;
      bmon_ram_model_i.mem[16'h0103] = 16'h0800;
      bmon_ram_model_i.mem[16'h028C] = 16'h0004;
      apb(1, 12'h000, 32'h0000_0002);
      apb(1, 12'h004, 32'h0000_0001);
      repeat (8) @(posedge clk);
      send(16'h1841, 0, 1);
      send(16'hBEEF, 0, 0);
      send(16'h1800, 0, 1);
      check(bmon_ram_model_i.mem[16'h0400], 16'h1841);
      check(bmon_ram_model_i.mem[16'h0800], 16'hBEEF);
      check(bmon_ram_model_i.mem[16'h0801], 16'h1800);
      apb(0, 12'h0FC, 0);
      check(pslverr, 1'b1);
      // Combined mode: an enabled command to the own address belongs to the terminal, not the stack.
      apb(1, 12'h004, 32'h0000_0002);
      bmon_ram_model_i.mem[16'h0294] = 16'h0004;
      bmon_ram_model_i.mem[16'h0401] = 16'h0000;
      apb(1, 12'h000, 32'h0000_0003);
      apb(1, 12'h004, 32'h0000_0001);
      repeat (8) @(posedge clk);
      send(16'h2841, 0, 1);
      send(16'hCAFE, 0, 0);
      send(16'h2800, 0, 1);
      check(bmon_ram_model_i.mem[16'h0401], 16'h0000);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1;
      repeat (3) @(posedge clk);
      word_mode();
      trigger();
      selective();
      summarize();
   end
endmodule // testbench
`default_nettype wire

// ==== core/bmon_params.svh ====
// Constants for the bus word and message monitor: register offsets, field positions,
// reset values, fixed shared RAM locations and timing counts.
// Assumes a 200 MHz core clock and a 16-bit word-addressed shared RAM.
`ifndef BMON_PARAMS_SVH
`define BMON_PARAMS_SVH
// APB byte offsets of the monitor registers.
`define BMON_OFS_CONFIG 12'h000
`define BMON_OFS_CONTROL 12'h004
`define BMON_OFS_TRIG_WORD 12'h008
`define BMON_OFS_INT_MASK 12'h00C
`define BMON_OFS_STACK_ADDR 12'h010
`define BMON_OFS_STATUS 12'h014
// Configuration register fields.
`define BMON_CFG_MODE_LO 0
`define BMON_CFG_AREA_B 2
`define BMON_CFG_TRIG_EN 3
`define BMON_CFG_START_ON 4
`define BMON_CFG_STOP_ON 5
`define BMON_CFG_SMALL_RAM 6
`define BMON_CFG_CMD_SZ_LO 7
`define BMON_CFG_DAT_SZ_LO 9
`define BMON_CFG_RESET 12'h000
`define BMON_CTL_START 0
`define BMON_CTL_STOP 1
`define BMON_MASK_PATTERN 0
// Fixed shared RAM locations.
`define BMON_WORD_PTR_A 16'h0100
`define BMON_WORD_PTR_B 16'h0104
`define BMON_CMD_PTR_A 16'h0102
`define BMON_DAT_PTR_A 16'h0103
`define BMON_CMD_PTR_B 16'h0106
`define BMON_DAT_PTR_B 16'h0107
`define BMON_LUT_BASE 16'h0280
`define BMON_TOP_LARGE 16'hFFFF
`define BMON_TOP_SMALL 16'h0FFF
`define BMON_CMD_STACK_MIN 16'h0100
`define BMON_DAT_STACK_MIN 16'h0200
`define BMON_BCAST_ADDR 5'h1F
// Tag word layout.
`define BMON_TAG_CHAN_B 15
`define BMON_TAG_VALID 14
`define BMON_TAG_CMD_SYNC 13
// Timing: gap resolution and message timeout.
`define BMON_CLK_MHZ 200
`define BMON_GAP_UNIT_US 1
`define BMON_GAP_UNIT_CYCLES (`BMON_CLK_MHZ * `BMON_GAP_UNIT_US)
`define BMON_MSG_TIMEOUT_US 20
`endif

// ==== core/bmon_pkg.sv ====
// Types shared by the bus monitor: modes, sequencer states and carrier structs.
// Assumes the constants of bmon_params.svh for field widths.
package bmon_pkg;
   typedef enum logic [1:0] {MODE_OFF, MODE_WORD, MODE_SEL, MODE_COMB} bmon_mode_type;
   typedef enum logic [3:0] {ST_IDLE, ST_LOAD_A, ST_LOAD_B, ST_RUN, ST_WR_WORD, ST_WR_TAG,
      ST_LUT, ST_WR_CMD, ST_WR_DATA, ST_WB_CMD, ST_WB_DAT} bmon_state_type;
   // One decoded 1553 word from the receivers.
   typedef struct packed {
      logic strobe;
      logic [15:0] data;
      logic chan_b;
      logic cmd_sync;
      logic err;
   } bmon_rx_word_type;
   // Request to the shared RAM arbiter.
   typedef struct packed {
      logic req;
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } bmon_ram_req_type;
   // Complete state of the monitor.
   typedef struct packed {
      bmon_state_type state;
      logic [11:0] cfg;
      logic [15:0] trig_word;
      logic irq_mask;
      logic active;
      logic stop_pend;
      logic [15:0] addr_cnt;
      logic [15:0] cmd_ptr;
      logic [15:0] cur_cmd;
      logic pend;
      logic [15:0] pend_data;
      logic [15:0] pend_tag;
      logic ext_s1;
      logic ext_s2;
      logic ext_prev;
      logic [7:0] gap_sub;
      logic [7:0] gap_us;
      logic in_msg;
      logic store;
      logic first;
      logic [5:0] remain;
      logic rd_wait;
      logic irq;
      logic [31:0] prdata;
      logic pslverr;
   } bmon_regs_type;
endpackage

// ==== core/bmon_top.sv ====
// Bus word and message monitor for a dual-redundant 1553 bus, writing into shared RAM.
// Assumes decoded words arrive from receivers on core_clk_in, a RAM arbiter that grants
// requests and returns read data the cycle after a granted read, and an APB master.
// How it works
// - Started word mode captures every command, status and data word from both buses.
// - Each captured word is written to RAM, then its tag word next.
// - Tag word carries bus channel, validity and gap time since previous word.
// - Word mode starts at the address held in pointer location 0100 for area A, 0104 for area B.
// - Current capture address sits in a counter readable as the stack address register.
// - Pointer locations 0100 and 0104 are overwritten, never skipped.
// - Capture counter wraps to zero after FFFF, or 0FFF for small RAM.
// - One 16-bit trigger word serves both pattern trigger and pattern interrupt.
// - Pattern interrupt fires only with its mask bit set.
// - With trigger enabled, a match starts or stops capture as configured.
// - A rising edge on the external trigger starts word capture.
// - Selective mode frames messages itself and stores them without the host.
// - Combined mode leaves own and broadcast address to the terminal, monitors the rest.
// - Message monitor has own command and data stacks with fixed pointer locations.
// - After a valid command, one lookup word is read at 0280 plus address offset.
// - Low four subaddress bits select the enable bit within the lookup word.
// - Bit 0 ignores the message; bit 1 stores command entry and data/status words.
// - Enabled terminal-to-terminal receive also stores the transmit command in data stack.
// - Lookup address: 15-10 zero, 9 one, 8 zero, 7 one, address, T/R, subaddress MSB.
// - Stack pointers at 102/106 and 103/107; lookup table occupies 0280 to 02FF.
// - Command stack 256 to 16K words, data stack 512 to 64K words.
//
// Local design decisions: the APB register port and the address map.
`include "bmon_params.svh"
`timescale 1ns/10ps
`default_nettype none
module bmon_top
   import bmon_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output var logic [31:0] prdata_out,
   output var logic pready_out,
   output var logic pslverr_out,
   input wire bmon_rx_word_type rx_word_in,
   input wire logic external_capture_start_input_in,
   input wire logic [4:0] terminal_address_bits_in,
   output var bmon_ram_req_type ram_out,
   input wire logic ram_gnt_in,
   input wire logic [15:0] ram_rdata_in,
   output var logic pattern_irq_out
);

   // Advance a pointer by one inside the aligned block that the mask describes.
   function automatic logic [15:0] f_wrap(input logic [15:0] ptr, input logic [15:0] mask);
      return (ptr & ~mask) | ((ptr + 16'h0001) & mask);
   endfunction

   // Words that follow a command: data words plus a status unless broadcast.
   function automatic logic [5:0] f_expect(input logic [15:0] cmd);
      logic [5:0] nd;
      nd = 6'h00;
      if (cmd[9:5] == 5'h00 || cmd[9:5] == 5'h1F) begin
         nd = {5'h00, cmd[4]};
      end else if (cmd[4:0] == 5'h00) begin
         nd = 6'h20;
      end else begin
         nd = {1'b0, cmd[4:0]};
      end
      return nd + ((cmd[15:11] == `BMON_BCAST_ADDR) ? 6'h00 : 6'h01);
   endfunction

   logic [1:0] rst_pipe_reg;
   logic rst_n_sync;
   bmon_regs_type st_reg;
   bmon_regs_type st_next;
   bmon_mode_type mode;
   logic word_mode;
   logic area_b;
   logic [15:0] top_mask;
   logic [15:0] cmd_mask;
   logic [15:0] dat_mask;
   logic [15:0] lut_addr;
   logic lut_bit;
   logic match;
   logic ext_rise;
   logic apb_setup;
   logic apb_wr;
   logic own_msg;

   // The reset is released through two flops so every state flop leaves reset together.
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_pipe_reg <= 2'h0;
      end else begin
         rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
      end
   end
   assign rst_n_sync = rst_pipe_reg[1];

   // Decoded configuration and addresses used throughout the sequencer.
   assign mode = bmon_mode_type'(st_reg.cfg[`BMON_CFG_MODE_LO +: 2]);
   assign word_mode = (mode == MODE_WORD);
   assign area_b = st_reg.cfg[`BMON_CFG_AREA_B];
   assign top_mask = st_reg.cfg[`BMON_CFG_SMALL_RAM] ? `BMON_TOP_SMALL : `BMON_TOP_LARGE;
   assign cmd_mask = (`BMON_CMD_STACK_MIN << {st_reg.cfg[`BMON_CFG_CMD_SZ_LO +: 2], 1'b0}) - 16'h0001;
   assign dat_mask = (`BMON_DAT_STACK_MIN << st_reg.cfg[`BMON_CFG_DAT_SZ_LO +: 3]) - 16'h0001;
   assign lut_addr = `BMON_LUT_BASE | {9'h000, st_reg.cur_cmd[15:10], st_reg.cur_cmd[9]};
   assign lut_bit = ram_rdata_in[st_reg.cur_cmd[8:5]];
   assign match = rx_word_in.strobe && word_mode && (rx_word_in.data == st_reg.trig_word);
   assign ext_rise = st_reg.ext_s2 && !st_reg.ext_prev;
   assign apb_setup = psel_in && !penable_in;
   assign apb_wr = psel_in && penable_in && pwrite_in;
   assign own_msg = (mode == MODE_COMB) && ((st_reg.pend_data[15:11] == terminal_address_bits_in)
      || (st_reg.pend_data[15:11] == `BMON_BCAST_ADDR));

   // Next-state logic: sequencer first, then trigger, bus and word capture so their sets win.
   always_comb begin
      st_next = st_reg;
      st_next.irq = 1'b0;
      st_next.ext_s1 = external_capture_start_input_in;
      st_next.ext_s2 = st_reg.ext_s1;
      st_next.ext_prev = st_reg.ext_s2;
      unique case (st_reg.state)
         ST_IDLE: begin
            st_next.pend = 1'b0;
            st_next.in_msg = 1'b0;
            st_next.rd_wait = 1'b0;
            if (st_reg.active && mode != MODE_OFF) begin
               st_next.state = ST_LOAD_A;
            end
         end
         ST_LOAD_A: begin
            if (st_reg.rd_wait) begin
               st_next.rd_wait = 1'b0;
               if (word_mode) begin
                  st_next.addr_cnt = ram_rdata_in;
                  st_next.state = ST_RUN;
               end else begin
                  st_next.cmd_ptr = ram_rdata_in;
                  st_next.state = ST_LOAD_B;
               end
            end else if (ram_gnt_in) begin
               st_next.rd_wait = 1'b1;
            end
         end
         ST_LOAD_B: begin
            if (st_reg.rd_wait) begin
               st_next.rd_wait = 1'b0;
               st_next.addr_cnt = ram_rdata_in;
               st_next.state = ST_RUN;
            end else if (ram_gnt_in) begin
               st_next.rd_wait = 1'b1;
            end
         end
         ST_RUN: begin
            if (!st_reg.active) begin
               // A stop in mid-message still writes the pointers back so the stacks stay consistent.
               st_next.in_msg = 1'b0;
               st_next.state = (st_reg.in_msg && st_reg.store) ? ST_WB_CMD : ST_IDLE;
            end else if (st_reg.pend) begin
               st_next.pend = 1'b0;
               if (word_mode) begin
                  st_next.state = ST_WR_WORD;
               end else if (!st_reg.in_msg) begin
                  // Only a valid command-sync word can open a message.
                  if (st_reg.pend_tag[`BMON_TAG_CMD_SYNC] && st_reg.pend_tag[`BMON_TAG_VALID]) begin
                     st_next.cur_cmd = st_reg.pend_data;
                     if (own_msg) begin
                        st_next.in_msg = 1'b1;
                        st_next.store = 1'b0;
                        st_next.first = 1'b1;
                        st_next.remain = f_expect(st_reg.pend_data);
                     end else begin
                        st_next.state = ST_LUT;
                     end
                  end
               end else begin
                  st_next.first = 1'b0;
                  if (st_reg.first && st_reg.pend_tag[`BMON_TAG_CMD_SYNC] && !st_reg.cur_cmd[10]) begin
                     st_next.remain = f_expect(st_reg.cur_cmd) + 6'h01;
                  end else begin
                     st_next.remain = st_reg.remain - 6'h01;
                  end
                  if (st_next.remain == 6'h00 || !st_reg.pend_tag[`BMON_TAG_VALID]) begin
                     st_next.in_msg = 1'b0;
                  end
                  if (st_reg.store) begin
                     st_next.state = ST_WR_DATA;
                  end
               end
            end else if (st_reg.in_msg && st_reg.gap_us >= 8'(`BMON_MSG_TIMEOUT_US)) begin
               // A silent bus ends the message so a lost response cannot stall framing.
               st_next.in_msg = 1'b0;
               st_next.state = st_reg.store ? ST_WB_CMD : ST_RUN;
            end
         end
         ST_WR_WORD: begin
            if (ram_gnt_in) begin
               st_next.addr_cnt = f_wrap(st_reg.addr_cnt, top_mask);
               st_next.state = ST_WR_TAG;
            end
         end
         ST_WR_TAG: begin
            if (ram_gnt_in) begin
               st_next.addr_cnt = f_wrap(st_reg.addr_cnt, top_mask);
               st_next.state = ST_RUN;
               if (st_reg.stop_pend) begin
                  st_next.active = 1'b0;
                  st_next.stop_pend = 1'b0;
               end
            end
         end
         ST_LUT: begin
            if (st_reg.rd_wait) begin
               st_next.rd_wait = 1'b0;
               st_next.store = lut_bit;
               st_next.in_msg = 1'b1;
               st_next.first = 1'b1;
               st_next.remain = f_expect(st_reg.cur_cmd);
               st_next.state = lut_bit ? ST_WR_CMD : ST_RUN;
            end else if (ram_gnt_in) begin
               st_next.rd_wait = 1'b1;
            end
         end
         ST_WR_CMD: begin
            if (ram_gnt_in) begin
               st_next.cmd_ptr = f_wrap(st_reg.cmd_ptr, cmd_mask);
               st_next.state = ST_RUN;
            end
         end
         ST_WR_DATA: begin
            if (ram_gnt_in) begin
               st_next.addr_cnt = f_wrap(st_reg.addr_cnt, dat_mask);
               st_next.state = st_reg.in_msg ? ST_RUN : ST_WB_CMD;
            end
         end
         ST_WB_CMD: begin
            if (ram_gnt_in) begin
               st_next.state = ST_WB_DAT;
            end
         end
         ST_WB_DAT: begin
            if (ram_gnt_in) begin
               st_next.state = ST_RUN;
            end
         end
      endcase
      // Pattern interrupt and trigger act on every word in word mode, so start-on-trigger works while stopped.
      if (match && st_reg.irq_mask) begin
         st_next.irq = 1'b1;
      end
      if (match && st_reg.cfg[`BMON_CFG_TRIG_EN]) begin
         if (st_reg.cfg[`BMON_CFG_START_ON]) begin
            st_next.active = 1'b1;
         end
         if (st_reg.cfg[`BMON_CFG_STOP_ON] && st_reg.active) begin
            st_next.stop_pend = 1'b1;
         end
      end
      if (ext_rise && word_mode) begin
         st_next.active = 1'b1;
      end
      // Read data is latched in the setup phase so the access phase answers from flops.
      if (apb_setup) begin
         st_next.pslverr = 1'b0;
         st_next.prdata = 32'h0000_0000;
         unique case (paddr_in)
            `BMON_OFS_CONFIG: st_next.prdata = {20'h0_0000, st_reg.cfg};
            `BMON_OFS_CONTROL: st_next.prdata = 32'h0000_0000;
            `BMON_OFS_TRIG_WORD: st_next.prdata = {16'h0000, st_reg.trig_word};
            `BMON_OFS_INT_MASK: st_next.prdata = {31'h0000_0000, st_reg.irq_mask};
            `BMON_OFS_STACK_ADDR: st_next.prdata = {16'h0000, st_reg.addr_cnt};
            `BMON_OFS_STATUS: st_next.prdata = {29'h0000_0000, st_reg.in_msg, st_reg.state != ST_IDLE,
               st_reg.active};
            default: st_next.pslverr = 1'b1;
         endcase
      end
      if (apb_wr) begin
         unique case (paddr_in)
            `BMON_OFS_CONFIG: st_next.cfg = pwdata_in[11:0];
            `BMON_OFS_TRIG_WORD: st_next.trig_word = pwdata_in[15:0];
            `BMON_OFS_INT_MASK: st_next.irq_mask = pwdata_in[`BMON_MASK_PATTERN];
            `BMON_OFS_CONTROL: begin
               if (pwdata_in[`BMON_CTL_START]) begin
                  st_next.active = 1'b1;
               end
               if (pwdata_in[`BMON_CTL_STOP]) begin
                  st_next.active = 1'b0;
                  st_next.stop_pend = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // Gap timer in microseconds; a new word latches the tag and restarts it.
      if (rx_word_in.strobe) begin
         st_next.pend = 1'b1;
         st_next.pend_data = rx_word_in.data;
         st_next.pend_tag = {rx_word_in.chan_b, !rx_word_in.err, rx_word_in.cmd_sync, 5'h00,
            st_reg.gap_us};
         st_next.gap_sub = 8'h00;
         st_next.gap_us = 8'h00;
      end else if (st_reg.gap_sub == 8'(`BMON_GAP_UNIT_CYCLES - 1)) begin
         st_next.gap_sub = 8'h00;
         st_next.gap_us = (st_reg.gap_us == 8'hFF) ? 8'hFF : st_reg.gap_us + 8'h01;
      end else begin
         st_next.gap_sub = st_reg.gap_sub + 8'h01;
      end
   end

   // Single state register of the whole monitor.
   always_ff @(posedge core_clk_in or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // RAM request follows the state; reads drop the request while waiting for data.
   always_comb begin
      ram_out = '0;
      unique case (st_reg.state)
         ST_LOAD_A: begin
            ram_out.req = !st_reg.rd_wait;
            if (word_mode) begin
               ram_out.addr = area_b ? `BMON_WORD_PTR_B : `BMON_WORD_PTR_A;
            end else begin
               ram_out.addr = area_b ? `BMON_CMD_PTR_B : `BMON_CMD_PTR_A;
            end
         end
         ST_LOAD_B: begin
            ram_out.req = !st_reg.rd_wait;
            ram_out.addr = area_b ? `BMON_DAT_PTR_B : `BMON_DAT_PTR_A;
         end
         ST_LUT: begin
            ram_out.req = !st_reg.rd_wait;
            ram_out.addr = lut_addr;
         end
         ST_WR_WORD, ST_WR_TAG, ST_WR_DATA: begin
            ram_out.req = 1'b1;
            ram_out.we = 1'b1;
            ram_out.addr = st_reg.addr_cnt;
            ram_out.wdata = (st_reg.state == ST_WR_TAG) ? st_reg.pend_tag : st_reg.pend_data;
         end
         ST_WR_CMD: begin
            ram_out.req = 1'b1;
            ram_out.we = 1'b1;
            ram_out.addr = st_reg.cmd_ptr;
            ram_out.wdata = st_reg.cur_cmd;
         end
         ST_WB_CMD, ST_WB_DAT: begin
            ram_out.req = 1'b1;
            ram_out.we = 1'b1;
            if (st_reg.state == ST_WB_CMD) begin
               ram_out.addr = area_b ? `BMON_CMD_PTR_B : `BMON_CMD_PTR_A;
               ram_out.wdata = st_reg.cmd_ptr;
            end else begin
               ram_out.addr = area_b ? `BMON_DAT_PTR_B : `BMON_DAT_PTR_A;
               ram_out.wdata = st_reg.addr_cnt;
            end
         end
         default: ;
      endcase
   end

   // Bus answers without wait states; data and error come from flops.
   assign pready_out = psel_in && penable_in;
   assign prdata_out = st_reg.prdata;
   assign pslverr_out = st_reg.pslverr;
   assign pattern_irq_out = st_reg.irq;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_sync);

   property p_tag_follows;
      (st_reg.state == ST_WR_WORD && ram_gnt_in) |=> (ram_out.we && ram_out.wdata == st_reg.pend_tag
         && ram_out.addr == f_wrap($past(ram_out.addr), top_mask));
   endproperty
   a_tag_follows: assert property (p_tag_follows) else $error("tag word not written after bus word");

   property p_word_ptr;
      (st_reg.state == ST_LOAD_A && word_mode && ram_out.req) |-> (!ram_out.we
         && ram_out.addr == (area_b ? `BMON_WORD_PTR_B : `BMON_WORD_PTR_A));
   endproperty
   a_word_ptr: assert property (p_word_ptr) else $error("word mode pointer read at wrong address");

   property p_wrap_top;
      (st_reg.state == ST_WR_TAG && ram_gnt_in && st_reg.addr_cnt == top_mask) |=> st_reg.addr_cnt == 16'h0000;
   endproperty
   a_wrap_top: assert property (p_wrap_top) else $error("capture counter did not wrap to zero");

   property p_irq_fire;
      (match && st_reg.irq_mask) |=> pattern_irq_out;
   endproperty
   a_irq_fire: assert property (p_irq_fire) else $error("pattern match gave no interrupt");

   property p_irq_gate;
      pattern_irq_out |-> ($past(st_reg.irq_mask) && $past(match));
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enabled match");

   property p_ext_start;
      (ext_rise && word_mode && !(apb_wr && paddr_in == `BMON_OFS_CONTROL)) |=> st_reg.active;
   endproperty
   a_ext_start: assert property (p_ext_start) else $error("external edge did not start capture");

   property p_lut_addr;
      (st_reg.state == ST_LUT && ram_out.req) |-> (ram_out.addr[15:10] == 6'h00 && ram_out.addr[9:7] == 3'h5
         && ram_out.addr[6:2] == st_reg.cur_cmd[15:11] && ram_out.addr[1] == st_reg.cur_cmd[10]
         && ram_out.addr[0] == st_reg.cur_cmd[9]);
   endproperty
   a_lut_addr: assert property (p_lut_addr) else $error("lookup address malformed");

   property p_lut_skip;
      (st_reg.state == ST_LUT && st_reg.rd_wait && !lut_bit) |=> (!st_reg.store && st_reg.state != ST_WR_CMD)
         ##1 (ram_out.we == 1'b0);
   endproperty
   a_lut_skip: assert property (p_lut_skip) else $error("disabled message was stored");

   property p_cmd_entry;
      (st_reg.state == ST_LUT && st_reg.rd_wait && lut_bit) |=> (ram_out.req && ram_out.we
         && ram_out.addr == st_reg.cmd_ptr && ram_out.wdata == st_reg.cur_cmd);
   endproperty
   a_cmd_entry: assert property (p_cmd_entry) else $error("enabled command not written to stack");

   c_word_capture: cover property (st_reg.state == ST_WR_TAG && ram_gnt_in);
   c_msg_stored: cover property (st_reg.state == ST_WB_DAT && ram_gnt_in);
   c_rt_to_rt: cover property (st_reg.state == ST_RUN && st_reg.pend && st_reg.in_msg && st_reg.first
      && st_reg.pend_tag[`BMON_TAG_CMD_SYNC] && !st_reg.cur_cmd[10]);
   c_trigger_stop: cover property (st_reg.stop_pend ##[1:20] !st_reg.active);

endmodule // bmon_top
`default_nettype wire
